// ---- src/gpt_pkg.sv ----
package gpt_pkg;
   localparam int NTMR = 4;
   localparam int CW = 16;
   localparam int MODE_W = 8;
   localparam int STAT_W = 8;
   localparam int AW = 8;

   // per-timer block at timer index * 0x10
   localparam logic [3:0] MODE_OFS = 4'h0;
   localparam logic [3:0] REF_OFS = 4'h4;
   localparam logic [3:0] CAP_OFS = 4'h8;
   localparam logic [3:0] CNT_OFS = 4'hC;
   localparam logic [AW-1:0] CFG_OFS = 8'h40;
   localparam logic [AW-1:0] STAT_OFS = 8'h44;
   localparam logic [AW-1:0] MASK_OFS = 8'h48;

   // mode register fields
   localparam int EN_BIT = 0;
   localparam int SRC_LSB = 1;
   localparam int EDGE_LSB = 3;
   localparam int TOG_BIT = 5;
   localparam int GEN_BIT = 6;
   localparam int GRST_BIT = 7;
   // status / mask fields
   localparam int MATCH_LSB = 0;
   localparam int CAPT_LSB = 4;

   localparam logic [MODE_W-1:0] MODE_RST = 8'h00;
   localparam logic [CW-1:0] REF_RST = 16'hFFFF;
   localparam logic [CW-1:0] CNT_RST = 16'h0000;
   localparam logic [CW-1:0] CNT_TOP = 16'hFFFF;
   localparam logic OUT_RST = 1'b1;
   localparam logic [1:0] CFG_RST = 2'h0;
   localparam logic [STAT_W-1:0] STAT_RST = 8'h00;

   // system clock divided by sixteen
   localparam int PRESCALE = 16;
   localparam logic [3:0] DIV_LAST = 4'(PRESCALE - 1);

   typedef enum logic [1:0] {
      SRC_CHAIN = 2'h0,
      SRC_SYS = 2'h1,
      SRC_DIV = 2'h2,
      SRC_PIN = 2'h3
   } gpt_src_t;

   typedef enum logic [1:0] {
      EDGE_NONE = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_FALL = 2'h2,
      EDGE_BOTH = 2'h3
   } gpt_edge_t;
endpackage

// ---- src/gpt_edge.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpt_edge (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   input wire gpt_pkg::gpt_edge_t edge_sel,
   output logic rise,
   output logic fall,
   output logic hit
);
   import gpt_pkg::*;

   logic prev_ff, nxt_prev;
   logic armed_ff, nxt_armed;

   // armed keeps a pin already high at reset from looking like an edge
   always_comb begin
      nxt_prev = pin;
      nxt_armed = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_ff <= 1'b0;
         armed_ff <= 1'b0;
      end else begin
         prev_ff <= nxt_prev;
         armed_ff <= nxt_armed;
      end
   end

   assign rise = armed_ff && pin && !prev_ff;
   assign fall = armed_ff && !pin && prev_ff;

   always_comb begin
      case (edge_sel)
         EDGE_RISE: hit = rise;
         EDGE_FALL: hit = fall;
         EDGE_BOTH: hit = rise || fall;
         default: hit = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// ---- src/gpt_top.sv ----
// What this block does
// (RL1) each timer counts one chosen source: other timer, clock, clock/16, pin
// (RL2) four external input pins, one per timer, for counting or capture
// (RL3) capture fires on rising, falling or both edges of the input
// (RL4) count reaching the reference drives an event on the timer's pin
// (RL5) that event is a one-cycle low pulse or a toggle of the pin
// (RL6) a timer's output can feed its neighbour, forming one 32-bit timer
// (RL7) gate a drives timers one and two, gate b three and four
// (RL8) uncascaded timers hold a 16-bit count and 16-bit reference
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module gpt_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [gpt_pkg::AW-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [gpt_pkg::NTMR-1:0] timer_ext_in,
   input wire logic timer_gate_a,
   input wire logic timer_gate_b,
   output logic [gpt_pkg::NTMR-1:0] timer_match_out,
   output logic irq
);
   import gpt_pkg::*;

   logic [MODE_W-1:0] mode_ff [NTMR];
   logic [MODE_W-1:0] nxt_mode [NTMR];
   logic [CW-1:0] ref_ff [NTMR];
   logic [CW-1:0] nxt_ref [NTMR];
   logic [CW-1:0] cnt_ff [NTMR];
   logic [CW-1:0] nxt_cnt [NTMR];
   logic [CW-1:0] cap_ff [NTMR];
   logic [CW-1:0] nxt_cap [NTMR];
   logic [NTMR-1:0] out_ff, nxt_out;
   logic [NTMR-1:0] mq_ff, nxt_mq;
   logic [1:0] cfg_ff, nxt_cfg;
   logic [STAT_W-1:0] stat_ff, nxt_stat, mask_ff, nxt_mask;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pslverr_ff, nxt_pslverr;
   logic [3:0] div_ff, nxt_div;
   logic div_tick;
   logic [NTMR-1:0] run, carry, mevt, clr, cap_evt, ext_rise;
   logic [1:0] pair_hit, gate_lvl, gate_rise;
   logic wr_en, setup;

   function automatic logic addr_is(input logic [AW-1:0] a,
                                    input logic [AW-1:0] ofs);
      return a[AW-1:2] == ofs[AW-1:2];
   endfunction

   function automatic logic [AW-1:0] tofs(input int i,
                                          input logic [3:0] ofs);
      return {2'b00, i[1:0], ofs};
   endfunction

   function automatic logic src_tick(input gpt_src_t s, input logic chain,
                                     input logic dtk, input logic pin);
      case (s)
         SRC_CHAIN: return chain;
         SRC_SYS: return 1'b1;
         SRC_DIV: return dtk;
         SRC_PIN: return pin;
         default: return 1'b0;
      endcase
   endfunction

   assign wr_en = psel && penable && pwrite;
   assign setup = psel && !penable;
   assign pready = 1'b1;
   assign prdata = prdata_ff;
   assign pslverr = pslverr_ff;
   assign timer_match_out = out_ff;
   assign irq = |(stat_ff & mask_ff);

   // shared prescaler keeps all clock/16 sources in step
   assign nxt_div = div_ff + 4'h1;
   assign div_tick = div_ff == DIV_LAST; // RL1

   assign gate_lvl = {timer_gate_b, timer_gate_a}; // RL7

   generate
      for (genvar gp = 0; gp < 2; gp++) begin : g_gate
         gpt_edge u_gate (
            .pclk(pclk),
            .presetn(presetn),
            .pin(gate_lvl[gp]),
            .edge_sel(EDGE_RISE),
            .rise(),
            .fall(),
            .hit(gate_rise[gp])
         );
         assign pair_hit[gp] = run[2*gp] && cnt_ff[2*gp] == ref_ff[2*gp]
            && cnt_ff[2*gp+1] == ref_ff[2*gp+1]; // RL6
      end

      for (genvar gi = 0; gi < NTMR; gi++) begin : g_tmr
         localparam int PREV = (gi + NTMR - 1) % NTMR;
         localparam int LOWI = gi - gi % 2;
         localparam int PAIR = gi / 2;
         logic casc, casc_hi, tk, gate_ok, restart, tog;

         gpt_edge u_in (
            .pclk(pclk),
            .presetn(presetn),
            .pin(timer_ext_in[gi]), // RL2
            .edge_sel(gpt_edge_t'(mode_ff[gi][EDGE_LSB +: 2])),
            .rise(ext_rise[gi]),
            .fall(),
            .hit(cap_evt[gi]) // RL3
         );

         assign casc = cfg_ff[PAIR];
         assign casc_hi = casc && (gi % 2 == 1);
         assign tog = mode_ff[gi][TOG_BIT];
         // chain source uses last cycle's match to avoid a loop of four
         assign tk = casc_hi ? carry[LOWI] :
            src_tick(gpt_src_t'(mode_ff[gi][SRC_LSB +: 2]), mq_ff[PREV],
                     div_tick, ext_rise[gi]); // RL1
         assign gate_ok = !mode_ff[gi][GEN_BIT] || gate_lvl[PAIR]; // RL7
         assign restart = mode_ff[gi][GEN_BIT] && mode_ff[gi][GRST_BIT]
            && gate_rise[PAIR]; // RL7
         assign run[gi] = mode_ff[gi][EN_BIT] && gate_ok && tk;
         assign carry[gi] = run[gi] && cnt_ff[gi] == CNT_TOP; // RL6
         assign mevt[gi] = casc ? (casc_hi && pair_hit[PAIR])
            : (run[gi] && cnt_ff[gi] == ref_ff[gi]); // RL4 RL8
         assign clr[gi] = restart || (casc ? pair_hit[PAIR] : mevt[gi]);

         always_comb begin
            nxt_cnt[gi] = cnt_ff[gi];
            if (clr[gi]) begin
               nxt_cnt[gi] = CNT_RST;
            end else if (run[gi]) begin
               nxt_cnt[gi] = cnt_ff[gi] + 16'h0001; // RL8
            end
            nxt_cap[gi] = cap_evt[gi] ? cnt_ff[gi] : cap_ff[gi]; // RL3
            nxt_mq[gi] = mevt[gi];
            // pulse mode idles high and drops for one clock
            if (mevt[gi]) begin
               nxt_out[gi] = tog ? !out_ff[gi] : 1'b0; // RL4 RL5
            end else begin
               nxt_out[gi] = tog ? out_ff[gi] : 1'b1; // RL5
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cnt_ff[gi] <= CNT_RST;
               cap_ff[gi] <= CNT_RST;
               mode_ff[gi] <= MODE_RST;
               ref_ff[gi] <= REF_RST;
            end else begin
               cnt_ff[gi] <= nxt_cnt[gi];
               cap_ff[gi] <= nxt_cap[gi];
               mode_ff[gi] <= nxt_mode[gi];
               ref_ff[gi] <= nxt_ref[gi];
            end
         end
      end
   endgenerate

   // register file; read data is sampled in the setup cycle
   always_comb begin
      nxt_cfg = cfg_ff;
      nxt_mask = mask_ff;
      nxt_prdata = prdata_ff;
      nxt_pslverr = pslverr_ff;
      for (int i = 0; i < NTMR; i++) begin
         nxt_mode[i] = mode_ff[i];
         nxt_ref[i] = ref_ff[i];
         if (wr_en && addr_is(paddr, tofs(i, MODE_OFS))) begin
            nxt_mode[i] = pwdata[MODE_W-1:0];
         end
         if (wr_en && addr_is(paddr, tofs(i, REF_OFS))) begin
            nxt_ref[i] = pwdata[CW-1:0];
         end
      end
      if (wr_en && addr_is(paddr, CFG_OFS)) begin
         nxt_cfg = pwdata[1:0]; // RL6
      end
      if (wr_en && addr_is(paddr, MASK_OFS)) begin
         nxt_mask = pwdata[STAT_W-1:0];
      end
      // a new event in the clearing cycle survives the write
      nxt_stat = stat_ff;
      if (wr_en && addr_is(paddr, STAT_OFS)) begin
         nxt_stat = stat_ff & ~pwdata[STAT_W-1:0];
      end
      nxt_stat = nxt_stat | {cap_evt, mevt};
      if (setup) begin
         nxt_prdata = 32'h0000_0000;
         nxt_pslverr = 1'b1;
         for (int i = 0; i < NTMR; i++) begin
            if (addr_is(paddr, tofs(i, MODE_OFS))) begin
               nxt_prdata = 32'(mode_ff[i]);
               nxt_pslverr = 1'b0;
            end
            if (addr_is(paddr, tofs(i, REF_OFS))) begin
               nxt_prdata = 32'(ref_ff[i]);
               nxt_pslverr = 1'b0;
            end
            if (addr_is(paddr, tofs(i, CAP_OFS))) begin
               nxt_prdata = 32'(cap_ff[i]);
               nxt_pslverr = 1'b0;
            end
            if (addr_is(paddr, tofs(i, CNT_OFS))) begin
               nxt_prdata = 32'(cnt_ff[i]);
               nxt_pslverr = 1'b0;
            end
         end
         if (addr_is(paddr, CFG_OFS)) begin
            nxt_prdata = 32'(cfg_ff);
            nxt_pslverr = 1'b0;
         end
         if (addr_is(paddr, STAT_OFS)) begin
            nxt_prdata = 32'(stat_ff);
            nxt_pslverr = 1'b0;
         end
         if (addr_is(paddr, MASK_OFS)) begin
            nxt_prdata = 32'(mask_ff);
            nxt_pslverr = 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_ff <= {NTMR{OUT_RST}};
         mq_ff <= '0;
         cfg_ff <= CFG_RST;
         stat_ff <= STAT_RST;
         mask_ff <= STAT_RST;
         prdata_ff <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
         div_ff <= 4'h0;
      end else begin
         out_ff <= nxt_out;
         mq_ff <= nxt_mq;
         cfg_ff <= nxt_cfg;
         stat_ff <= nxt_stat;
         mask_ff <= nxt_mask;
         prdata_ff <= nxt_prdata;
         pslverr_ff <= nxt_pslverr;
         div_ff <= nxt_div;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_low_pulse;
      !timer_match_out[0] ##1 timer_match_out[0];
   endsequence

   a_div_period: assert property (div_tick |-> ##16 div_tick) // RL1
      else $error("clock/16 tick not every 16 cycles");
   a_hold_disabled: assert property (!mode_ff[1][EN_BIT] && !clr[1] // RL1
      |=> $stable(cnt_ff[1]))
      else $error("timer 1 counted while disabled");
   a_ext_count: assert property (mode_ff[2][SRC_LSB +: 2] == SRC_PIN // RL2
      && !cfg_ff[1] && mode_ff[2][EN_BIT] && !mode_ff[2][GEN_BIT]
      && $rose(timer_ext_in[2]) && !clr[2]
      |=> cnt_ff[2] == $past(cnt_ff[2]) + 16'h0001)
      else $error("pin rise did not advance timer 2");
   a_cap_rise_only: assert property ($fell(timer_ext_in[1]) // RL3
      && mode_ff[1][EDGE_LSB +: 2] == EDGE_RISE |-> !cap_evt[1])
      else $error("rising-only capture fired on a fall");
   a_cap_value: assert property (cap_evt[1] // RL3
      |=> cap_ff[1] == $past(cnt_ff[1]))
      else $error("captured value is not the count");
   a_match_pulse: assert property (mevt[0] && !mode_ff[0][TOG_BIT] // RL4
      && ref_ff[0] != 16'h0000 |=> s_low_pulse)
      else $error("pulse mode did not give one low cycle");
   a_toggle_out: assert property (mevt[1] && mode_ff[1][TOG_BIT] // RL5
      |=> timer_match_out[1] != $past(timer_match_out[1]))
      else $error("toggle mode did not invert the pin");
   a_casc_carry: assert property (cfg_ff[0] && carry[0] // RL6
      && !pair_hit[0] && !clr[1] && mode_ff[1][EN_BIT]
      && !mode_ff[1][GEN_BIT] |=> cnt_ff[1] == $past(cnt_ff[1]) + 16'h0001)
      else $error("low half wrap did not advance high half");
   a_gate_hold: assert property (mode_ff[3][GEN_BIT] && !cfg_ff[1] // RL7
      && !timer_gate_b && !gate_rise[1] |=> $stable(cnt_ff[3]))
      else $error("closed gate let timer 3 move");
   a_wrap_ref: assert property (!cfg_ff[0] && run[0] // RL8
      && cnt_ff[0] == ref_ff[0] |=> cnt_ff[0] == 16'h0000)
      else $error("16-bit timer did not restart at reference");
endmodule
`default_nettype wire

// ---- dv/gpt_board.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpt_board (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [gpt_pkg::NTMR-1:0] pin_req,
   input wire logic [1:0] gate_req,
   output logic [gpt_pkg::NTMR-1:0] timer_ext_in,
   output logic timer_gate_a,
   output logic timer_gate_b
);
   // launched just after the edge, like a board flop would
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_ext_in <= '0;
         timer_gate_a <= 1'b0;
         timer_gate_b <= 1'b0;
      end else begin
         timer_ext_in <= pin_req;
         timer_gate_a <= gate_req[0];
         timer_gate_b <= gate_req[1];
      end
   end
endmodule
`default_nettype wire

// ---- dv/general_purpose_timer_group_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(s, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
   $display("[FAIL] %s exp %0h got %0h", s, e, g); end end
module general_purpose_timer_group_bench;
   import gpt_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [AW-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [NTMR-1:0] pin_req, ext_in, mout;
   logic [1:0] gate_req;
   logic gate_a, gate_b;
   int errors, check_count, n, rf;

   gpt_top u_gpt_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_ext_in(ext_in), .timer_gate_a(gate_a), .timer_gate_b(gate_b),
      .timer_match_out(mout), .irq(irq));
   gpt_board u_gpt_board (.pclk(pclk), .presetn(presetn), .pin_req(pin_req),
      .gate_req(gate_req), .timer_ext_in(ext_in), .timer_gate_a(gate_a),
      .timer_gate_b(gate_b));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   function automatic logic [7:0] ra(input int i, input logic [3:0] o);
      return {4'(i), o};
   endfunction

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, string s);
      apb(1'b0, a, 32'h0);
      `CHK(s, e, rd)
   endtask

   // pulse waits for low; toggle waits for any change of level
   task automatic wait_ev(input int i, input logic tog, input int lim);
      logic v;
      v = mout[i];
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while ((tog ? mout[i] === v : mout[i] !== 1'b0) && n < lim);
   endtask

   task automatic pulse(input int i);
      pin_req[i] <= 1'b1;
      repeat (2) @(posedge pclk);
      pin_req[i] <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask

   initial begin
      repeat (90000) @(posedge pclk);
      errors++;
      tally_and_finish();
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata, pin_req, gate_req} = '0;
      presetn = 1'b0;
      errors = 0;
      check_count = 0;
      void'($urandom(32'hd0562529));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      `CHK("out_rst", 4'hF, mout)
      chk_rd(ra(0, REF_OFS), 32'(REF_RST), "ref_rst");
      apb(1'b1, ra(2, REF_OFS), 32'hABCD_1234);
      chk_rd(ra(2, REF_OFS), 32'h1234, "ref_16");
      apb(1'b0, 8'h80, 32'h0);
      `CHK("slverr", 1'b1, err)
      rf = 2 + $urandom_range(0, 13);
      apb(1'b1, MASK_OFS, 32'h01);
      apb(1'b1, ra(0, REF_OFS), rf);
      apb(1'b1, ra(0, MODE_OFS), 32'h03);
      wait_ev(0, 1'b0, 100);
      @(negedge pclk);
      `CHK("pulse_w", 1'b1, mout[0])
      `CHK("irq_set", 1'b1, irq)
      wait_ev(0, 1'b0, 100);
      `CHK("period", rf, n)
      apb(1'b1, ra(0, MODE_OFS), 32'h0);
      apb(1'b1, STAT_OFS, 32'hFF);
      @(negedge pclk);
      `CHK("irq_clr", 1'b0, irq)
      apb(1'b1, ra(1, REF_OFS), rf);
      apb(1'b1, ra(1, MODE_OFS), 32'h23);
      wait_ev(1, 1'b1, 100);
      wait_ev(1, 1'b1, 100);
      `CHK("tog_per", rf + 1, n)
      `CHK("irq_mask", 1'b0, irq)
      apb(1'b1, ra(1, MODE_OFS), 32'h0);
      // pin-counting timer two, gated timer three
      apb(1'b1, ra(2, MODE_OFS), 32'h07);
      apb(1'b1, ra(3, MODE_OFS), 32'h43);
      rf = 1 + $urandom_range(0, 9);
      repeat (rf) pulse(2);
      chk_rd(ra(2, CNT_OFS), rf, "pin_cnt");
      chk_rd(ra(3, CNT_OFS), 32'h0, "gated");
      gate_req <= 2'b10;
      repeat (20) @(posedge pclk);
      apb(1'b0, ra(3, CNT_OFS), 32'h0);
      `CHK("gate_run", 1'b1, rd >= 32'd20)
      // gate restart: count cleared at the gate's rise, two ticks before read
      apb(1'b1, ra(3, MODE_OFS), 32'hC3);
      gate_req <= 2'b00;
      repeat (3) @(posedge pclk);
      gate_req <= 2'b10;
      repeat (3) @(posedge pclk);
      chk_rd(ra(3, CNT_OFS), 32'h2, "gate_rst");
      for (int e = 1; e < 4; e++) begin
         apb(1'b1, ra(1, MODE_OFS), 32'(e << EDGE_LSB));
         apb(1'b1, STAT_OFS, 32'hFF);
         pin_req[1] <= 1'b1;
         repeat (3) @(posedge pclk);
         apb(1'b0, STAT_OFS, 32'h0);
         `CHK("cap_rise", e[0], rd[CAPT_LSB + 1])
         apb(1'b1, STAT_OFS, 32'hFF);
         pin_req[1] <= 1'b0;
         repeat (3) @(posedge pclk);
         apb(1'b0, STAT_OFS, 32'h0);
         `CHK("cap_fall", e[1], rd[CAPT_LSB + 1])
      end
      // capture was taken while the count stood still
      apb(1'b0, ra(1, CNT_OFS), 32'h0);
      n = rd;
      chk_rd(ra(1, CAP_OFS), n, "cap_val");
      // second reset, then timers zero and one as one wide counter
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      `CHK("out_rst2", 4'hF, mout)
      // clock/16 source on timer two, chained into toggling timer three
      apb(1'b1, ra(3, REF_OFS), 32'h0);
      apb(1'b1, ra(3, MODE_OFS), 32'h21);
      apb(1'b1, ra(2, REF_OFS), 32'h1);
      apb(1'b1, ra(2, MODE_OFS), 32'h05);
      wait_ev(3, 1'b1, 100);
      wait_ev(3, 1'b1, 100);
      `CHK("chain_per", 2 * PRESCALE, n)
      wait_ev(2, 1'b0, 100);
      @(negedge pclk);
      wait_ev(2, 1'b0, 100);
      `CHK("div_per", 2 * PRESCALE - 1, n)
      apb(1'b1, ra(2, MODE_OFS), 32'h0);
      apb(1'b1, ra(3, MODE_OFS), 32'h0);
      apb(1'b1, STAT_OFS, 32'hFF);
      apb(1'b1, CFG_OFS, 32'h1);
      apb(1'b1, ra(1, REF_OFS), 32'h1);
      apb(1'b1, ra(0, REF_OFS), 32'h0);
      apb(1'b1, ra(1, MODE_OFS), 32'h1);
      apb(1'b1, ra(0, MODE_OFS), 32'h3);
      wait_ev(1, 1'b0, 70000);
      `CHK("casc_per", 1'b1, (n > 65530 && n < 65540))
      chk_rd(STAT_OFS, 32'h02, "casc_stat");
      tally_and_finish();
   end
endmodule
`default_nettype wire
